// ### rtl/aio_cfg.svh
`ifndef AIO_CFG_SVH
`define AIO_CFG_SVH

// Register offsets.
`define AIO_OFS_MIN_ALARM   8'h08
`define AIO_OFS_HOUR_ALARM  8'h09
`define AIO_OFS_WDAY_ALARM  8'h0a
`define AIO_OFS_EXT         8'h0d
`define AIO_OFS_FLAG        8'h0e
`define AIO_OFS_CTRL        8'h0f

// Field positions.
`define AIO_BIT_FIELD_DIS   7
`define AIO_BIT_WDSEL       6
`define AIO_BIT_UF          5
`define AIO_BIT_TF          4
`define AIO_BIT_AF          3
`define AIO_BIT_UIE         5
`define AIO_BIT_TIE         4
`define AIO_BIT_AIE         3
`define AIO_BIT_RESET       0

// Reset values.
`define AIO_RST_ALARM       8'h00
`define AIO_RST_EXT         8'h00
`define AIO_RST_FLAG        8'h00
`define AIO_RST_CTRL        8'h40

// Writable and readable bit masks.
`define AIO_CTRL_WMASK      8'hf9
`define AIO_FLAG_RMASK      8'h38

`endif

// ### rtl/aio_pkg.sv
package aio_pkg;
  typedef logic [7:0] aio_byte_t;
  typedef enum logic [1:0] {
    AIO_ST_IDLE  = 2'b00,
    AIO_ST_ARMED = 2'b01
  } aio_state_t;
endpackage

// ### rtl/aio_alarm_irq.sv
`timescale 1ns/1ps
`default_nettype none
`include "aio_cfg.svh"

module aio_alarm_irq (
  // Clock and reset.
  input  wire logic           ref_clk_i,
  input  wire logic           rst_i,
  // Register port.
  input  wire logic           reg_wr_i,
  input  wire logic [7:0]     reg_addr_i,
  input  wire aio_pkg::aio_byte_t reg_wdata_i,
  output var  aio_pkg::aio_byte_t reg_rdata_o,
  // Running calendar.
  input  wire logic           cal_tick_i,
  input  wire logic [7:0]     cal_min_i,
  input  wire logic [7:0]     cal_hour_i,
  input  wire logic [7:0]     cal_week_i,
  input  wire logic [7:0]     cal_day_i,
  // Other interrupt events.
  input  wire logic           timer_event_i,
  input  wire logic           update_event_i,
  // Open-drain interrupt pin.
  output logic                irq_n_o,
  output logic                irq_n_oe_o
);
  import aio_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Registers.
  aio_byte_t  min_alarm_q;
  aio_byte_t  min_alarm_d;
  aio_byte_t  hour_alarm_q;
  aio_byte_t  hour_alarm_d;
  aio_byte_t  wday_alarm_q;
  aio_byte_t  wday_alarm_d;
  aio_byte_t  ext_q;
  aio_byte_t  ext_d;
  aio_byte_t  ctrl_q;
  aio_byte_t  ctrl_d;
  logic [2:0] flag_q;
  logic [2:0] flag_d;
  logic [2:0] flag_event;
  logic [2:0] flag_clear;
  logic [2:0] flag_enable;
  logic       match_q;
  logic       match_d;
  aio_state_t state_q;
  aio_state_t state_d;
  aio_byte_t  rdata_q;
  aio_byte_t  rdata_d;
  logic       irq_q;
  logic       irq_d;

  logic       min_ok;
  logic       hour_ok;
  logic       wday_ok;
  logic       match_now;
  logic       alarm_event;
  logic       alarm_irq_enable;
  logic       timer_irq_enable;
  logic       update_irq_enable;
  logic       week_or_date_select;
  logic       in_reset;
  logic       flag_wr;

  // Enables follow the next control value, so a cleared enable releases the pin on the write edge.
  assign alarm_irq_enable    = ctrl_d[`AIO_BIT_AIE];
  assign timer_irq_enable    = ctrl_d[`AIO_BIT_TIE];
  assign update_irq_enable   = ctrl_d[`AIO_BIT_UIE];
  assign week_or_date_select = ext_q[`AIO_BIT_WDSEL];
  assign in_reset            = ctrl_q[`AIO_BIT_RESET];
  assign flag_wr             = reg_wr_i && (reg_addr_i == `AIO_OFS_FLAG);

  ////////////////////////////////////////////////////////////////////////////
  // Alarm comparison.
  always_comb begin
    min_ok  = (min_alarm_q[6:0] == cal_min_i[6:0]);
    if (min_alarm_q[`AIO_BIT_FIELD_DIS]) begin
      min_ok = 1'b1;
    end
    hour_ok = (hour_alarm_q[5:0] == cal_hour_i[5:0]);
    if (hour_alarm_q[`AIO_BIT_FIELD_DIS]) begin
      hour_ok = 1'b1;
    end
    if (wday_alarm_q[`AIO_BIT_FIELD_DIS]) begin
      wday_ok = 1'b1;
    end else if (week_or_date_select) begin
      wday_ok = (wday_alarm_q[5:0] == cal_day_i[5:0]);
    end else begin
      wday_ok = |(wday_alarm_q[6:0] & cal_week_i[6:0]);
    end
    match_now = min_ok && hour_ok && wday_ok;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Edge qualifier: armed by the first tick outside reset; fires only on a match after a tick with no match.
  always_comb begin
    match_d     = match_q;
    state_d     = state_q;
    alarm_event = 1'b0;
    case (state_q)
      AIO_ST_IDLE: begin
        if (cal_tick_i && !in_reset) begin
          state_d = AIO_ST_ARMED;
          match_d = match_now;
        end
      end
      AIO_ST_ARMED: begin
        if (in_reset) begin
          state_d = AIO_ST_IDLE;
        end else if (cal_tick_i) begin
          match_d     = match_now;
          alarm_event = match_now && !match_q;
        end
      end
      default: begin
        state_d = AIO_ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Qualifier state.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      match_q <= 1'b0;
      state_q <= AIO_ST_IDLE;
    end else begin
      match_q <= match_d;
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes.
  always_comb begin
    min_alarm_d  = min_alarm_q;
    hour_alarm_d = hour_alarm_q;
    wday_alarm_d = wday_alarm_q;
    ext_d        = ext_q;
    ctrl_d       = ctrl_q;
    if (reg_wr_i) begin
      case (reg_addr_i)
        `AIO_OFS_MIN_ALARM: begin
          min_alarm_d = reg_wdata_i;
        end
        `AIO_OFS_HOUR_ALARM: begin
          hour_alarm_d = reg_wdata_i;
        end
        `AIO_OFS_WDAY_ALARM: begin
          wday_alarm_d = reg_wdata_i;
        end
        `AIO_OFS_EXT: begin
          ext_d = reg_wdata_i;
        end
        `AIO_OFS_CTRL: begin
          // Bits 2 and 1 have no storage and always read zero.
          ctrl_d = reg_wdata_i & `AIO_CTRL_WMASK;
        end
        default: begin
          ctrl_d = ctrl_q;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      min_alarm_q  <= `AIO_RST_ALARM;
      hour_alarm_q <= `AIO_RST_ALARM;
      wday_alarm_q <= `AIO_RST_ALARM;
      ext_q        <= `AIO_RST_EXT;
      ctrl_q       <= `AIO_RST_CTRL;
    end else begin
      min_alarm_q  <= min_alarm_d;
      hour_alarm_q <= hour_alarm_d;
      wday_alarm_q <= wday_alarm_d;
      ext_q        <= ext_d;
      ctrl_q       <= ctrl_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt flags: bit 0 alarm, bit 1 timer, bit 2 update.
  assign flag_event  = {update_event_i, timer_event_i, alarm_event};
  assign flag_enable = {update_irq_enable, timer_irq_enable, alarm_irq_enable};
  // Only a written zero clears a flag; written ones are ignored.
  assign flag_clear  = {3{flag_wr}} & ~{reg_wdata_i[`AIO_BIT_UF], reg_wdata_i[`AIO_BIT_TF],
                                        reg_wdata_i[`AIO_BIT_AF]};

  for (genvar i = 0; i < 3; i++) begin : g_flag
    // A set in the same cycle as a clearing write wins, so no event is lost.
    always_comb begin
      flag_d[i] = flag_q[i];
      if (flag_clear[i]) begin
        flag_d[i] = 1'b0;
      end
      if (flag_event[i]) begin
        flag_d[i] = 1'b1;
      end
    end

    always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
        flag_q[i] <= 1'b0;
      end else begin
        flag_q[i] <= flag_d[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data and interrupt output.
  always_comb begin
    case (reg_addr_i)
      `AIO_OFS_MIN_ALARM: begin
        rdata_d = min_alarm_q;
      end
      `AIO_OFS_HOUR_ALARM: begin
        rdata_d = hour_alarm_q;
      end
      `AIO_OFS_WDAY_ALARM: begin
        rdata_d = wday_alarm_q;
      end
      `AIO_OFS_EXT: begin
        rdata_d = ext_q;
      end
      `AIO_OFS_FLAG: begin
        rdata_d = {2'b00, flag_q[2], flag_q[1], flag_q[0], 3'b000};
      end
      `AIO_OFS_CTRL: begin
        rdata_d = ctrl_q;
      end
      default: begin
        rdata_d = 8'h00;
      end
    endcase
    // The pin is pulled low while any flag meets its own enable.
    irq_d = |(flag_d & flag_enable);
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rdata_q <= 8'h00;
      irq_q   <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      irq_q   <= irq_d;
    end
  end

  assign reg_rdata_o = rdata_q;
  assign irq_n_o     = 1'b0;
  assign irq_n_oe_o  = irq_q;

endmodule
`default_nettype wire

// ### test/aio_alarm_irq_checker.sv
`timescale 1ns/1ps
`default_nettype none
module aio_irq_checker (
  // Clock, reset and registers.
  input wire logic               ref_clk_i,
  input wire logic               rst_i,
  input wire logic               reg_wr_i,
  input wire logic [7:0]         reg_addr_i,
  input wire aio_pkg::aio_byte_t reg_wdata_i,
  input wire aio_pkg::aio_byte_t reg_rdata_o,
  // Events and pin.
  input wire logic               cal_tick_i,
  input wire logic               timer_event_i,
  input wire logic               update_event_i,
  input wire logic               irq_n_o,
  input wire logic               irq_n_oe_o
);
  import aio_pkg::*;
  aio_byte_t ctrl_q;
  aio_byte_t ctrl_d;
  logic      wc;
  logic      ev;
  assign wc = reg_wr_i && reg_addr_i == 8'h0f;
  assign ev = cal_tick_i || timer_event_i || update_event_i;
  always_comb ctrl_d = wc ? reg_wdata_i : ctrl_q;
  always_ff @(posedge ref_clk_i) ctrl_q <= rst_i ? 8'h40 : ctrl_d;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  a_pin_low_only: assert property (irq_n_o == 1'b0)
    else $error("Pin level not low.");
  a_flag_release: assert property (reg_wr_i && reg_addr_i == 8'h0e && reg_wdata_i == 8'h00 && !ev |=> !irq_n_oe_o)
    else $error("Pin held after flags cleared.");
  a_no_enable_quiet: assert property (ctrl_d[5:3] == 3'b000 |=> !irq_n_oe_o)
    else $error("Pin driven with no enable.");
  a_timer_drive: assert property (timer_event_i && ctrl_d[4] |=> irq_n_oe_o)
    else $error("Timer event not driving pin.");
  a_update_drive: assert property (update_event_i && ctrl_d[5] |=> irq_n_oe_o)
    else $error("Update event not driving pin.");
  a_low_holds: assert property (irq_n_oe_o && !reg_wr_i |=> irq_n_oe_o)
    else $error("Pin released by itself.");
  a_reset_mutes: assert property (ctrl_q[0] && ctrl_q[5:3] == 3'b001 && !wc && !irq_n_oe_o |=> !irq_n_oe_o)
    else $error("Alarm fired while held in reset.");
  a_unmapped_zero: assert property (!(reg_addr_i inside {8'h08, 8'h09, 8'h0a, 8'h0d, 8'h0e, 8'h0f}) |=> reg_rdata_o == 8'h00)
    else $error("Unmapped read not zero.");
endmodule
bind aio_alarm_irq aio_irq_checker aio_irq_checker_inst (.*);
`default_nettype wire

// ### test/aio_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module aio_host_model (
  // Open-drain pin.
  input  wire logic irq_n_o,
  input  wire logic irq_n_oe_o,
  // Level seen by the host.
  output var  logic irq_line_o
);
  // The pull-up holds the shared line high when no source drives it.
  assign irq_line_o = irq_n_oe_o ? irq_n_o : 1'b1;
endmodule
`default_nettype wire

// ### test/test_aio_alarm_irq.sv
`timescale 1ns/1ps
`default_nettype none
module test_aio_alarm_irq;
  import aio_pkg::*;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       wr = 1'b0, tick = 1'b0, tev = 1'b0, uev = 1'b0;
  logic [7:0] addr = 8'h00, mn = 8'h00, hr = 8'h00, wk = 8'h00, dy = 8'h00;
  aio_byte_t  wdata = 8'h00, rdata;
  logic       irq_n, oe, line;
  int         miscompares = 0, compares = 0;
  always #5 clk = ~clk;
  aio_alarm_irq aio_alarm_irq_inst (.ref_clk_i(clk), .rst_i(rst), .reg_wr_i(wr), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_rdata_o(rdata), .cal_tick_i(tick), .cal_min_i(mn), .cal_hour_i(hr), .cal_week_i(wk),
    .cal_day_i(dy), .timer_event_i(tev), .update_event_i(uev), .irq_n_o(irq_n), .irq_n_oe_o(oe));
  aio_host_model aio_host_model_inst (.irq_n_o(irq_n), .irq_n_oe_o(oe), .irq_line_o(line));
  task automatic chk(string n, logic [7:0] s, logic [7:0] e);
    compares++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic cyc;
    @(posedge clk);
    #1;
  endtask
  task automatic put(logic [7:0] a, logic [7:0] d);
    cyc();
    {wr, addr, wdata} = {1'b1, a, d};
    cyc();
    wr = 1'b0;
  endtask
  task automatic get(logic [7:0] a, logic [7:0] e, string n);
    cyc();
    addr = a;
    cyc();
    chk(n, rdata, e);
  endtask
  task automatic pin(logic e);
    chk("pin", {7'h00, line}, {7'h00, e});
  endtask
  task automatic tk(logic [7:0] m, logic [7:0] h, logic [7:0] w, logic [7:0] d);
    cyc();
    {tick, mn, hr, wk, dy} = {1'b1, m, h, w, d};
    cyc();
    tick = 1'b0;
  endtask
  task automatic pulse(logic t);
    cyc();
    {tev, uev} = {t, !t};
    cyc();
    {tev, uev} = 2'b00;
  endtask
  task automatic t_alarm;
    get(8'h0f, 8'h40, "ctl reset");
    get(8'h0e, 8'h00, "flag reset");
    put(8'h0a, 8'h80);
    put(8'h09, 8'h18);
    put(8'h08, 8'h59);
    put(8'h0f, 8'h08);
    tk(8'h58, 8'h18, 8'h01, 8'h01);
    tk(8'h59, 8'h18, 8'h01, 8'h01);
    pin(1'b0);
    put(8'h0e, 8'h38);
    get(8'h0e, 8'h08, "flag");
    put(8'h0f, 8'h00);
    pin(1'b1);
    put(8'h0f, 8'h08);
    pin(1'b0);
    put(8'h0e, 8'h00);
    pin(1'b1);
    tk(8'h59, 8'h18, 8'h01, 8'h01);
    pin(1'b1);
    put(8'h0f, 8'h00);
    tk(8'h00, 8'h19, 8'h01, 8'h01);
    tk(8'h59, 8'h18, 8'h01, 8'h01);
    pin(1'b1);
    get(8'h0e, 8'h08, "flag off");
    put(8'h0e, 8'h00);
    $display("alarm test done");
  endtask
  task automatic t_day;
    logic [7:0] m = 8'h2a;
    put(8'h09, 8'h80);
    put(8'h08, 8'h80);
    put(8'h0a, m);
    for (int d = 0; d < 7; d++) begin
      tk(8'h00, 8'h00, 8'h01 << d, 8'h01);
      get(8'h0e, m[d] ? 8'h08 : 8'h00, "week flag");
      put(8'h0e, 8'h00);
    end
    put(8'h0d, 8'h40);
    put(8'h0a, 8'h15);
    put(8'h09, 8'h07);
    tk(8'h00, 8'h07, 8'h02, 8'h14);
    tk(8'h00, 8'h07, 8'h02, 8'h15);
    get(8'h0e, 8'h08, "date flag");
    put(8'h0e, 8'h00);
    put(8'h0f, 8'h09);
    tk(8'h00, 8'h07, 8'h02, 8'h16);
    tk(8'h00, 8'h07, 8'h02, 8'h15);
    get(8'h0e, 8'h00, "reset flag");
    put(8'h0f, 8'h00);
    $display("day test done");
  endtask
  task automatic t_other;
    put(8'h0f, 8'h10);
    pulse(1'b1);
    pin(1'b0);
    put(8'h0f, 8'h20);
    pin(1'b1);
    pulse(1'b0);
    get(8'h0e, 8'h30, "flags");
    put(8'h0e, 8'h00);
    pin(1'b1);
    put(8'h0f, 8'hff);
    get(8'h0f, 8'hf9, "ctl");
    get(8'h2b, 8'h00, "unmapped");
    put(8'h0f, 8'h00);
    $display("other test done");
  endtask
  task automatic wrap_up;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (12) cyc();
    rst = 1'b0;
    t_alarm();
    t_day();
    t_other();
    wrap_up();
  end
  initial begin
    #100000;
    miscompares++;
    wrap_up();
  end
endmodule
`default_nettype wire
